// file: mch_pkg.sv
// Shared constants and carriers for the MAC handshake block.
package mch_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS     = 50;
  localparam int MDC_MIN_NS = 400;
  // Half period of the management clock, rounded up so it is never too fast.
  localparam int MDC_HALF   = (MDC_MIN_NS / 2 + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // Host register map and fields
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h01;
  localparam logic [7:0] A_MCTL = 8'h02;
  localparam logic [7:0] A_MPHY = 8'h03;
  localparam logic [7:0] A_MDLO = 8'h04;
  localparam logic [7:0] A_MDHI = 8'h05;
  localparam int CTRL_TXGO = 0;
  localparam int CTRL_RXGO = 1;
  localparam int MCTL_RW   = 5;
  localparam int MCTL_GO   = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ****************************************
  // Management frame
  // ****************************************
  localparam logic [5:0] MD_LAST  = 6'h3f;
  localparam logic [5:0] MD_ADEND = 6'h2e;
  localparam logic [5:0] MD_DATA0 = 6'h30;

  localparam int TX_STAT_W = 16;

  typedef struct packed {
    logic       eof;
    logic       err;
    logic       ovf;
    logic [7:0] data;
  } mch_rxw_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_READ = 2'b01,
    TX_STAT = 2'b10
  } mch_txst_t;

endpackage

// file: mch_mac.sv
// Receive buffer and the MAC handshake logic for host, management, client and GMII.
`timescale 1ns/10ps

// Small synchronous FIFO; out_ready may stall so the buffer really fills.
module mch_fifo #(
  parameter int W = 11,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  // Handshakes come straight from the fill count.
  assign in_ready  = (cnt_ff != D[AW:0]);
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage has no reset; only the pointers and the fill count need a known start.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= wp_ff + AW'(push);
      rp_ff  <= rp_ff + AW'(pop);
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// What this block does
// RQ1 - A received frame with errors raises the receive error on its last byte.
// RQ2 - On receive buffer overflow stop writing the frame and flag overflow.
// RQ3 - Client samples the overflow flag together with the end-of-frame marker.
// RQ4 - Client raises frame-available when a whole frame waits to be sent.
// RQ5 - Once available, read and send bytes until the client marks the last one.
// RQ6 - After a frame, pulse statistics-enable to qualify the statistics vector.
// RQ7 - Pulse transmit-done when a frame went out successfully.
// RQ8 - Empty together with end-of-frame still gives a valid frame and done.
// RQ9 - Empty before end-of-frame stops reading, drops the frame, flags discard.
// RQ10 - Host write uses select and write strobe; device ends it with ready.
// RQ11 - Host read uses select and read strobe; device answers ready and data valid.
// RQ12 - Management write keeps the output enabled for the whole transfer.
// RQ13 - Management read enables output only during the address, then releases.
// RQ14 - Transmit byte and enable are driven on the transmit clock.
// RQ15 - Transmit error is raised while an errored frame is sent.
// RQ16 - Receive byte and data valid are sampled on each receive clock rise.
// RQ17 - Receive error during a frame marks that frame errored.
// RQ18 - The transmit clock is the transmit reference clock.
// RQ19 - Receive error and overflow flags stand in the end-of-frame cycle.
module mch_mac (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       hcs_n,
  input  wire logic       hwrite_n,
  input  wire logic       hread_n,
  input  wire logic [7:0] haddr,
  input  wire logic [7:0] hdatain,
  output logic [7:0]      hdataout,
  output logic            hdataout_en_n,
  output logic            hready_n,
  output logic            mdc,
  output logic            mdo,
  output logic            mdio_out_en_n,
  input  wire logic       mdi,
  input  wire logic       gtx_clk,
  input  wire logic       tx_fifoavail,
  input  wire logic [7:0] tx_fifodata,
  input  wire logic       tx_fifoeof,
  input  wire logic       tx_fifoempty,
  output logic            tx_fiforead,
  output logic            tx_done,
  output logic            tx_staten,
  output logic [15:0]     tx_statvec,
  output logic            tx_disfrm,
  output logic [7:0]      txd,
  output logic            tx_en,
  output logic            tx_er,
  input  wire logic       rx_clk,
  input  wire logic [7:0] rxd,
  input  wire logic       rx_dv,
  input  wire logic       rx_er,
  input  wire logic       rx_fifo_full,
  output logic            rx_wr,
  output logic [7:0]      rx_data,
  output logic            rx_eof,
  output logic            rx_error,
  output logic            rx_fifo_error
);

  // ****************************************
  // Host port (mclk)
  // ****************************************
  logic [7:0]  ctrl_ff;
  logic        hact_ff;
  logic        hstb;
  logic        hready_n_ff;
  logic        hden_n_ff;
  logic [7:0]  hdout_ff;
  logic [7:0]  nxt_hdout;
  logic [4:0]  mphy_ff;
  logic [7:0]  mctl_ff;
  logic [15:0] mwd_ff;
  logic [15:0] mrd_ff;
  logic        md_busy_ff;
  logic        md_fin_ff;
  logic        md_go;
  logic        txb_m_ff;
  logic        txb_s_ff;
  logic        rxb_m_ff;
  logic        rxb_s_ff;
  logic        tx_busy_ff;
  logic        rx_busy_ff;

  // A transfer is taken once, on the first cycle the strobe is seen.
  assign hstb  = ~hcs_n & (~hwrite_n | ~hread_n) & ~hact_ff;
  assign md_go = hstb & ~hwrite_n & (haddr == mch_pkg::A_MCTL) &
                 hdatain[mch_pkg::MCTL_GO] & ~md_busy_ff;

  // Read data is chosen from the address; unmapped addresses read zero.
  always_comb begin
    nxt_hdout = 8'h00;
    unique case (haddr)
      mch_pkg::A_CTRL: nxt_hdout = ctrl_ff;
      mch_pkg::A_STAT: nxt_hdout = {5'h00, md_fin_ff, rxb_s_ff, txb_s_ff};
      mch_pkg::A_MCTL: nxt_hdout = mctl_ff;
      mch_pkg::A_MPHY: nxt_hdout = {3'h0, mphy_ff};
      mch_pkg::A_MDLO: nxt_hdout = mrd_ff[7:0];
      mch_pkg::A_MDHI: nxt_hdout = mrd_ff[15:8];
      default:         nxt_hdout = 8'h00;
    endcase
  end

  // Ready pulses one cycle after the strobe; data-valid pulses with it on reads only.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hact_ff     <= 1'b0;
      hready_n_ff <= 1'b1;
      hden_n_ff   <= 1'b1;
      hdout_ff    <= 8'h00;
    end else begin
      hact_ff     <= ~hcs_n & (~hwrite_n | ~hread_n);
      hready_n_ff <= ~hstb; // RQ10
      hden_n_ff   <= ~(hstb & ~hread_n); // RQ11
      hdout_ff    <= (hstb & ~hread_n) ? nxt_hdout : hdout_ff;
    end
  end

  // Writes land in the control registers; a busy management port ignores MCTL.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= mch_pkg::CTRL_RST;
      mctl_ff <= 8'h00;
      mphy_ff <= 5'h00;
      mwd_ff  <= 16'h0000;
    end else if (hstb & ~hwrite_n) begin
      unique case (haddr)
        mch_pkg::A_CTRL: ctrl_ff <= hdatain;
        mch_pkg::A_MCTL: mctl_ff <= md_busy_ff ? mctl_ff : hdatain;
        mch_pkg::A_MPHY: mphy_ff <= hdatain[4:0];
        mch_pkg::A_MDLO: mwd_ff[7:0] <= hdatain;
        mch_pkg::A_MDHI: mwd_ff[15:8] <= hdatain;
        default: ;
      endcase
    end
  end

  assign hready_n      = hready_n_ff;
  assign hdataout_en_n = hden_n_ff;
  assign hdataout      = hdout_ff;

  // Busy levels from the link domains cross on two flops each.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      txb_m_ff <= 1'b0;
      txb_s_ff <= 1'b0;
      rxb_m_ff <= 1'b0;
      rxb_s_ff <= 1'b0;
    end else begin
      // Each busy level is a flop in its own domain, so no decode glitch is caught.
      txb_m_ff <= tx_busy_ff;
      txb_s_ff <= txb_m_ff;
      rxb_m_ff <= rx_busy_ff;
      rxb_s_ff <= rxb_m_ff;
    end
  end

  // ****************************************
  // Management serial port (mclk)
  // ****************************************
  logic [2:0]  div_ff;
  logic        mdc_ff;
  logic [5:0]  md_cnt_ff;
  logic [63:0] md_sh_ff;
  logic        md_rw_ff;
  logic        mdi_m_ff;
  logic        mdi_s_ff;
  logic        tick;

  assign tick = md_busy_ff & (div_ff == 3'(mch_pkg::MDC_HALF - 1));

  // The serial input comes from the PHY's clock world and is synchronised.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mdi_m_ff <= 1'b0;
      mdi_s_ff <= 1'b0;
    end else begin
      mdi_m_ff <= mdi;
      mdi_s_ff <= mdi_m_ff;
    end
  end

  // Bits change on the falling edge of mdc and are sampled on its rise.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff     <= 3'h0;
      mdc_ff     <= 1'b0;
      md_cnt_ff  <= 6'h00;
      md_sh_ff   <= 64'h0;
      md_rw_ff   <= 1'b0;
      md_busy_ff <= 1'b0;
      md_fin_ff  <= 1'b0;
      mrd_ff     <= 16'h0000;
    end else if (md_go) begin
      div_ff     <= 3'h0;
      mdc_ff     <= 1'b0;
      md_cnt_ff  <= 6'h00;
      md_rw_ff   <= hdatain[mch_pkg::MCTL_RW];
      md_busy_ff <= 1'b1;
      md_fin_ff  <= 1'b0;
      md_sh_ff   <= {32'hffffffff, 2'b01,
                     hdatain[mch_pkg::MCTL_RW] ? 2'b01 : 2'b10,
                     mphy_ff, hdatain[4:0], 2'b10, mwd_ff};
    end else if (md_busy_ff) begin
      div_ff <= tick ? 3'h0 : div_ff + 3'h1;
      if (tick) begin
        mdc_ff <= ~mdc_ff;
        if (mdc_ff) begin
          md_sh_ff  <= {md_sh_ff[62:0], 1'b0};
          md_cnt_ff <= md_cnt_ff + 6'h01;
          md_busy_ff <= md_cnt_ff != mch_pkg::MD_LAST;
          md_fin_ff  <= md_cnt_ff == mch_pkg::MD_LAST;
        end else if (~md_rw_ff & (md_cnt_ff >= mch_pkg::MD_DATA0)) begin
          mrd_ff <= {mrd_ff[14:0], mdi_s_ff};
        end
      end
    end
  end

  assign mdc = mdc_ff;
  assign mdo = md_sh_ff[63];
  // Reads hand the wire to the PHY from turnaround onward.
  assign mdio_out_en_n = ~(md_busy_ff & (md_rw_ff | (md_cnt_ff < mch_pkg::MD_ADEND))); // RQ12 RQ13

  // ****************************************
  // Transmit path (gtx_clk)
  // ****************************************
  mch_pkg::mch_txst_t tx_st_ff;
  logic        txg_m_ff;
  logic        txg_s_ff;
  logic [7:0]  txd_ff;
  logic        txen_ff;
  logic        txer_ff;
  logic        abort_ff;
  logic [14:0] txcnt_ff;
  logic        done_ff;
  logic        staten_ff;
  logic        disfrm_ff;
  logic [15:0] statv_ff;
  logic        tx_abort;

  assign tx_fiforead = (tx_st_ff == mch_pkg::TX_READ); // RQ5
  assign tx_abort    = tx_fiforead & tx_fifoempty & ~tx_fifoeof;

  // All transmit state runs on gtx_clk, the transmit reference.
  always_ff @(posedge gtx_clk or posedge sys_rst) begin // RQ18
    if (sys_rst) begin
      txg_m_ff <= 1'b0;
      txg_s_ff   <= 1'b0;
      tx_st_ff   <= mch_pkg::TX_IDLE;
      tx_busy_ff <= 1'b0;
    end else begin
      txg_m_ff   <= ctrl_ff[mch_pkg::CTRL_TXGO];
      txg_s_ff   <= txg_m_ff;
      tx_busy_ff <= tx_st_ff != mch_pkg::TX_IDLE;
      unique case (tx_st_ff)
        mch_pkg::TX_IDLE: if (txg_s_ff & tx_fifoavail) tx_st_ff <= mch_pkg::TX_READ;
        mch_pkg::TX_READ: if (tx_fifoeof | tx_fifoempty) tx_st_ff <= mch_pkg::TX_STAT; // RQ8 RQ9
        mch_pkg::TX_STAT: tx_st_ff <= mch_pkg::TX_IDLE;
        default:          tx_st_ff <= mch_pkg::TX_IDLE;
      endcase
    end
  end

  // Each byte read goes out the next cycle; an abort corrupts the frame.
  always_ff @(posedge gtx_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txd_ff    <= 8'h00;
      txen_ff   <= 1'b0;
      txer_ff   <= 1'b0;
      disfrm_ff <= 1'b0;
    end else begin
      txd_ff    <= tx_fiforead ? tx_fifodata : 8'h00; // RQ14
      txen_ff   <= tx_fiforead;
      txer_ff   <= tx_abort; // RQ15
      disfrm_ff <= tx_abort; // RQ9
    end
  end

  // Statistics and done follow the last byte by one cycle.
  always_ff @(posedge gtx_clk or posedge sys_rst) begin
    if (sys_rst) begin
      abort_ff  <= 1'b0;
      txcnt_ff  <= 15'h0000;
      done_ff   <= 1'b0;
      staten_ff <= 1'b0;
      statv_ff  <= 16'h0000;
    end else begin
      staten_ff <= tx_st_ff == mch_pkg::TX_STAT; // RQ6
      done_ff   <= (tx_st_ff == mch_pkg::TX_STAT) & ~abort_ff; // RQ7 RQ8
      if (tx_st_ff == mch_pkg::TX_STAT) begin
        statv_ff <= {abort_ff, txcnt_ff};
      end
      if (tx_st_ff == mch_pkg::TX_IDLE) begin
        abort_ff <= 1'b0;
        txcnt_ff <= 15'h0000;
      end else if (tx_fiforead) begin
        abort_ff <= tx_abort;
        txcnt_ff <= txcnt_ff + 15'h0001;
      end
    end
  end

  assign txd        = txd_ff;
  assign tx_en      = txen_ff;
  assign tx_er      = txer_ff;
  assign tx_done    = done_ff;
  assign tx_staten  = staten_ff;
  assign tx_statvec = statv_ff;
  assign tx_disfrm  = disfrm_ff;

  // ****************************************
  // Receive path (rx_clk)
  // ****************************************
  logic [7:0]        rxd_q_ff;
  logic              rxdv_q_ff;
  logic              rxer_q_ff;
  logic              rxg_m_ff;
  logic              rxg_s_ff;
  logic              rx_act_ff;
  logic              eofp_ff;
  logic [7:0]        pend_ff;
  logic              err_ff;
  logic              ovf_ff;
  logic              fin_valid;
  logic              fin_ready;
  mch_pkg::mch_rxw_t fin_word;
  logic              fout_valid;
  mch_pkg::mch_rxw_t fout_word;

  // GMII inputs are captured on every rising receive clock.
  always_ff @(posedge rx_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxd_q_ff  <= 8'h00;
      rxdv_q_ff <= 1'b0;
      rxer_q_ff <= 1'b0;
      rxg_m_ff  <= 1'b0;
      rxg_s_ff   <= 1'b0;
      rx_busy_ff <= 1'b0;
    end else begin
      rxd_q_ff   <= rxd; // RQ16
      rxdv_q_ff  <= rx_dv;
      rxer_q_ff  <= rx_er;
      rxg_m_ff   <= ctrl_ff[mch_pkg::CTRL_RXGO];
      rxg_s_ff   <= rxg_m_ff;
      rx_busy_ff <= rx_act_ff | eofp_ff;
    end
  end

  // One byte is held back so the last one can carry the end marker.
  // Bytes arriving while an end marker waits are dropped; that is rare
  // because the inter-frame gap is far longer than the buffer drain.
  always_ff @(posedge rx_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_act_ff <= 1'b0;
      eofp_ff   <= 1'b0;
      pend_ff   <= 8'h00;
      err_ff    <= 1'b0;
      ovf_ff    <= 1'b0;
    end else if (eofp_ff) begin
      eofp_ff <= ~fin_ready;
    end else if (~rx_act_ff) begin
      if (rxdv_q_ff & rxg_s_ff) begin
        rx_act_ff <= 1'b1;
        pend_ff   <= rxd_q_ff;
        err_ff    <= rxer_q_ff;
        ovf_ff    <= 1'b0;
      end
    end else if (rxdv_q_ff) begin
      pend_ff <= rxd_q_ff;
      err_ff  <= err_ff | rxer_q_ff; // RQ17
      ovf_ff  <= ovf_ff | ~fin_ready; // RQ2
    end else begin
      rx_act_ff <= 1'b0;
      eofp_ff   <= 1'b1;
    end
  end

  // After overflow only the end marker is written, still carrying the flags.
  assign fin_valid     = eofp_ff | (rx_act_ff & rxdv_q_ff & ~ovf_ff); // RQ2
  assign fin_word.eof  = eofp_ff;
  assign fin_word.err  = err_ff; // RQ1
  assign fin_word.ovf  = ovf_ff;
  assign fin_word.data = pend_ff;

  mch_fifo #(
    .W ($bits(mch_pkg::mch_rxw_t)),
    .D (4)
  ) u_rxbuf (
    .clk       (rx_clk),
    .rst       (sys_rst),
    .in_valid  (fin_valid),
    .in_ready  (fin_ready),
    .in_data   (fin_word),
    .out_valid (fout_valid),
    .out_ready (~rx_fifo_full),
    .out_data  (fout_word)
  );

  // Client write strobe; error flags appear only with the end marker.
  assign rx_wr         = fout_valid & ~rx_fifo_full;
  assign rx_data       = fout_word.data;
  assign rx_eof        = rx_wr & fout_word.eof;
  assign rx_error      = rx_eof & fout_word.err; // RQ1 RQ19
  assign rx_fifo_error = rx_eof & fout_word.ovf; // RQ3 RQ19

  // ****************************************
  // Checks
  // ****************************************
  a_rx_err_eof: assert property (@(posedge rx_clk) disable iff (sys_rst) // RQ19
    (rx_error | rx_fifo_error) |-> (rx_eof & rx_wr))
    else $error("Receive flags outside end of frame.");
  a_rx_ovf_stop: assert property (@(posedge rx_clk) disable iff (sys_rst) // RQ2
    (rx_act_ff & rxdv_q_ff & ~fin_ready & ~eofp_ff) |=> ovf_ff & (~fin_valid | fin_word.eof))
    else $error("Writing continued after overflow.");
  a_rx_er_mark: assert property (@(posedge rx_clk) disable iff (sys_rst) // RQ17
    (rx_act_ff & rxdv_q_ff & rxer_q_ff & ~eofp_ff) |=> err_ff)
    else $error("Receive error not recorded.");
  a_rx_sample_in: assert property (@(posedge rx_clk) disable iff (sys_rst) // RQ16
    1'b1 |=> (rxd_q_ff == $past(rxd)) && (rxdv_q_ff == $past(rx_dv)))
    else $error("Receive inputs not sampled.");
  a_tx_byte_out: assert property (@(posedge gtx_clk) disable iff (sys_rst) // RQ14
    tx_fiforead |=> tx_en && (txd == $past(tx_fifodata)))
    else $error("Transmit byte not driven after read.");
  a_tx_stat_qual: assert property (@(posedge gtx_clk) disable iff (sys_rst) // RQ6
    $fell(tx_en) |-> tx_staten ##1 ~tx_staten)
    else $error("Statistics enable not pulsed after frame.");
  a_tx_done_good: assert property (@(posedge gtx_clk) disable iff (sys_rst) // RQ7
    (tx_fiforead & tx_fifoeof) |=> ~tx_er ##1 (tx_done & tx_staten & ~tx_statvec[15]))
    else $error("Done missing after good frame.");
  a_tx_abort_flag: assert property (@(posedge gtx_clk) disable iff (sys_rst) // RQ9
    tx_abort |=> (tx_disfrm & tx_er) ##1 (~tx_en & ~tx_fiforead & ~tx_done & tx_staten))
    else $error("Abort not handled.");
  a_host_ready: assert property (@(posedge mclk) disable iff (sys_rst) // RQ10
    hstb |=> ~hready_n ##1 hready_n)
    else $error("Host ready not pulsed once.");
  a_host_rdata: assert property (@(posedge mclk) disable iff (sys_rst) // RQ11
    (hstb & ~hread_n) |=> (~hdataout_en_n & ~hready_n))
    else $error("Read data valid missing.");
  a_md_write_oe: assert property (@(posedge mclk) disable iff (sys_rst) // RQ12
    (md_busy_ff & md_rw_ff) |-> ~mdio_out_en_n)
    else $error("Output released during write.");
  a_md_read_rel: assert property (@(posedge mclk) disable iff (sys_rst) // RQ13
    (md_busy_ff & ~md_rw_ff & (md_cnt_ff >= mch_pkg::MD_ADEND)) |-> mdio_out_en_n)
    else $error("Output held during read data.");

  c_tx_good: cover property (@(posedge gtx_clk) disable iff (sys_rst) tx_done);
  c_tx_abort: cover property (@(posedge gtx_clk) disable iff (sys_rst) tx_disfrm);
  c_rx_ovf: cover property (@(posedge rx_clk) disable iff (sys_rst) rx_fifo_error);
  c_md_read: cover property (@(posedge mclk) disable iff (sys_rst) $rose(md_fin_ff) & ~md_rw_ff);

endmodule

// file: mch_txcli.sv
// Client transmit FIFO model that offers frames to the MAC.
`timescale 1ns/10ps
module mch_txcli (
  input  wire logic       gtx_clk,
  input  wire logic       sys_rst,
  input  wire logic       load,
  input  wire logic [3:0] len,
  input  wire logic [3:0] cut,
  input  wire logic       emp,
  input  wire logic       tx_fiforead,
  output logic            tx_fifoavail,
  output logic [7:0]      tx_fifodata,
  output logic            tx_fifoeof,
  output logic            tx_fifoempty
);
  logic [3:0] idx_ff;
  logic       busy_ff;

  // Show-ahead byte; outside a read the bus carries a filler pattern made from the index, not the next byte.
  assign tx_fifodata  = tx_fiforead ? {4'h1, idx_ff} : {~idx_ff, idx_ff};
  assign tx_fifoavail = busy_ff;
  assign tx_fifoeof   = tx_fiforead && (idx_ff == len - 4'h1);
  // A nonzero cut runs the FIFO dry before the last byte; emp marks empty on the last.
  assign tx_fifoempty = tx_fiforead && ((cut != 4'h0) ? (idx_ff == cut - 4'h1) :
                                        (emp && idx_ff == len - 4'h1));

  // The frame is offered whole and withdrawn once its final byte, or the byte that runs it empty, is taken.
  always_ff @(posedge gtx_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_ff <= 1'b0;
      idx_ff  <= 4'h0;
    end else if (load) begin
      busy_ff <= 1'b1;
      idx_ff  <= 4'h0;
    end else if (tx_fiforead) begin
      idx_ff <= idx_ff + 4'h1;
      if (tx_fifoeof || tx_fifoempty) begin
        busy_ff <= 1'b0;
      end
    end
  end
endmodule

// file: tb.sv
// Self-checking bench for the MAC handshake block.
`timescale 1ns/10ps
module tb;
  logic        mclk = 1'b0, gtx_clk = 1'b0, rx_clk = 1'b0, sys_rst = 1'b1, mdc_q = 1'b0;
  logic        hcs_n = 1'b1, hwrite_n = 1'b1, hread_n = 1'b1, mdc, mdo, mdio_out_en_n;
  logic [7:0]  haddr = 8'h00, hdatain = 8'h00, hdataout, txd, tx_fifodata, rx_data;
  logic [7:0]  rxd = 8'h00;
  logic        hdataout_en_n, hready_n, tx_fifoavail, tx_fifoeof, tx_fifoempty, tx_fiforead;
  logic        tx_done, tx_staten, tx_disfrm, tx_en, tx_er, rx_wr, rx_eof, rx_error;
  logic        rx_fifo_error, rx_dv = 1'b0, rx_er = 1'b0, rx_fifo_full = 1'b0;
  logic        load = 1'b0, emp = 1'b0;
  logic [3:0]  len = 4'h0, cut = 4'h0;
  logic [15:0] tx_statvec, statv;
  int          bad_count = 0, comparisons = 0, ndone, nstat, ndis, ner, noe;
  logic [7:0]  txq[$];
  mch_pkg::mch_rxw_t rxq[$];
  // The management line has a pull-up, so it reads high whenever nobody drives it.
  wire         mdio_w = mdio_out_en_n ? 1'b1 : mdo;

  mch_mac i_dut (.mclk, .sys_rst, .hcs_n, .hwrite_n, .hread_n, .haddr, .hdatain, .hdataout,
    .hdataout_en_n, .hready_n, .mdc, .mdo, .mdio_out_en_n, .mdi(mdio_w), .gtx_clk,
    .tx_fifoavail, .tx_fifodata, .tx_fifoeof, .tx_fifoempty, .tx_fiforead, .tx_done,
    .tx_staten, .tx_statvec, .tx_disfrm, .txd, .tx_en, .tx_er, .rx_clk, .rxd, .rx_dv,
    .rx_er, .rx_fifo_full, .rx_wr, .rx_data, .rx_eof, .rx_error, .rx_fifo_error);
  mch_txcli i_cli (.gtx_clk, .sys_rst, .load, .len, .cut, .emp, .tx_fiforead,
    .tx_fifoavail, .tx_fifodata, .tx_fifoeof, .tx_fifoempty);

  // ****************************************
  // Clocks and monitors
  // ****************************************
  initial forever #25 mclk = ~mclk;
  // Offset so that no transmit edge lands on the release of reset.
  initial begin
    #3;
    forever #32 gtx_clk = ~gtx_clk;
  end
  initial begin
    #7;
    forever #32 rx_clk = ~rx_clk;
  end

  // Transmit outputs are sampled half a cycle after they launch.
  always @(negedge gtx_clk) begin
    if (tx_en === 1'b1) txq.push_back(txd);
    if (tx_done === 1'b1) ndone++;
    if (tx_disfrm === 1'b1) ndis++;
    if (tx_er === 1'b1) ner++;
    if (tx_staten === 1'b1) begin
      nstat++;
      statv = tx_statvec;
    end
  end

  // Error flags are taken together with the word that carries them.
  always @(negedge rx_clk) begin
    #1;
    if (rx_wr === 1'b1) rxq.push_back({rx_eof, rx_error, rx_fifo_error, rx_data});
  end

  // Count the management bits during which the device drives the line.
  always @(negedge mclk) begin
    if (mdc === 1'b1 && mdc_q === 1'b0 && mdio_out_en_n === 1'b0) noe++;
    mdc_q = mdc;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One host cycle; the strobe is held until ready is seen, then released.
  task automatic host(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    int k;
    @(negedge mclk);
    hcs_n = 1'b0;
    hwrite_n = ~wr;
    hread_n = wr;
    haddr = a;
    hdatain = d;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (hready_n !== 1'b0 && k < 20);
    q = hdataout;
    chk(hready_n === 1'b0 && hdataout_en_n === wr, "host handshake");
    // Keep the request up through the edge that samples ready low.
    @(negedge mclk);
    hcs_n = 1'b1;
    hwrite_n = 1'b1;
    hread_n = 1'b1;
  endtask

  task automatic send_tx(input logic [3:0] n, input logic [3:0] c, input logic e);
    int k;
    txq.delete();
    ndone = 0;
    nstat = 0;
    ndis = 0;
    ner = 0;
    @(negedge gtx_clk);
    len = n;
    cut = c;
    emp = e;
    load = 1'b1;
    @(negedge gtx_clk);
    load = 1'b0;
    k = 0;
    while (nstat == 0 && k < 100) begin
      @(negedge gtx_clk);
      k++;
    end
    repeat (2) @(negedge gtx_clk);
  endtask

  task automatic send_rx(input int n, input int er_at, input logic full);
    rxq.delete();
    @(negedge rx_clk);
    rx_fifo_full = full;
    for (int i = 0; i < n; i++) begin
      rx_dv = 1'b1;
      rxd = 8'h40 + 8'(i);
      rx_er = (i == er_at);
      @(negedge rx_clk);
    end
    rx_dv = 1'b0;
    rx_er = 1'b0;
    rxd = ~rxd;
    repeat (20) @(negedge rx_clk);
    rx_fifo_full = 1'b0;
    repeat (20) @(negedge rx_clk);
  endtask

  task automatic mgmt(input logic [7:0] cmd, input int exp);
    logic [7:0] q;
    int k;
    noe = 0;
    host(1'b1, mch_pkg::A_MCTL, cmd, q);
    k = 0;
    q = 8'h00;
    while (q[2] !== 1'b1 && k < 400) begin
      host(1'b0, mch_pkg::A_STAT, 8'h00, q);
      k++;
    end
    chk(noe == exp, "mdio enable span");
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic [7:0] q;
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    chk(hready_n === 1'b1 && tx_en === 1'b0 && rx_wr === 1'b0 && mdc === 1'b0, "reset");
    host(1'b1, mch_pkg::A_CTRL, 8'h03, q);
    host(1'b0, mch_pkg::A_CTRL, 8'h00, q);
    chk(q === 8'h03, "ctrl readback");
    host(1'b0, 8'h7f, 8'h00, q);
    chk(q === 8'h00, "unmapped read");
    send_tx(4'h5, 4'h0, 1'b0);
    chk(txq.size() == 5 && ndone == 1 && ndis == 0, "good frame");
    chk(nstat == 1 && statv === 16'h0005, "stat vector");
    foreach (txq[i]) chk(txq[i] === {4'h1, i[3:0]}, "tx byte");
    send_tx(4'h4, 4'h0, 1'b1);
    chk(txq.size() == 4 && ndone == 1 && ndis == 0, "empty with eof");
    send_tx(4'h6, 4'h3, 1'b0);
    chk(txq.size() == 3 && ndone == 0 && ndis == 1 && ner == 1, "abort");
    chk(statv[15] === 1'b1, "abort flag");
    send_rx(4, 2, 1'b0);
    chk(rxq.size() == 4 && rxq[3].eof === 1'b1 && rxq[3].err === 1'b1, "rx err");
    foreach (rxq[i]) chk(rxq[i].data === 8'h40 + i[7:0] && rxq[i].ovf === 1'b0, "rx");
    send_rx(12, 15, 1'b1);
    chk(rxq.size() < 12 && rxq[$].eof === 1'b1 && rxq[$].ovf === 1'b1, "overflow");
    host(1'b1, mch_pkg::A_MPHY, 8'h01, q);
    mgmt(8'ha3, 64);
    mgmt(8'h83, 46);
    host(1'b0, mch_pkg::A_MDLO, 8'h00, q);
    chk(q === 8'hff, "read data from released line");
    give_verdict();
  end

  // The whole run needs well under a tenth of this span.
  initial begin
    #1000000;
    bad_count++;
    give_verdict();
  end
endmodule
